// file: rtl/sd_irq_pkg.sv
package sd_irq_pkg;

	localparam logic [7:0]  MASK_OFFSET     = 8'h00;
	localparam logic [7:0]  ENABLE_OFFSET   = 8'h04;
	localparam logic [7:0]  CTRL2_OFFSET    = 8'h08;
	localparam logic [7:0]  FLAG_OFFSET     = 8'h0C;
	localparam logic [7:0]  ISTAT_OFFSET    = 8'h10;
	localparam logic [7:0]  IMASK_OFFSET    = 8'h14;

	localparam logic [31:0] EVENT_BITS      = 32'h017F7137;
	localparam logic [31:0] ERROR_BITS      = 32'h017F0000;
	localparam int          SUMMARY_BIT     = 15;
	localparam logic [31:0] CTRL2_RW_BITS   = 32'h00870000;
	localparam logic [31:0] CTRL2_RO_BITS   = 32'h0000009F;
	localparam int          TUNED_BIT       = 23;
	localparam int          TUNE_START_BIT  = 22;
	localparam int          SPEED_LSB       = 16;
	localparam logic [31:0] RESET_VALUE     = 32'h00000000;

	localparam logic [2:0]  SPEED_SDR12     = 3'h0;
	localparam logic [2:0]  SPEED_SDR25     = 3'h1;
	localparam logic [2:0]  SPEED_SDR50     = 3'h2;
	localparam logic [2:0]  SPEED_SDR104    = 3'h3;
	localparam logic [2:0]  SPEED_DDR50     = 3'h4;

	localparam int          LOCAL_EVENTS    = 3;
	localparam logic [2:0]  LOCAL_RESET     = 3'h0;

	typedef struct packed {
		logic       auto_stop_error;
		logic       auto_index_error;
		logic       auto_endbit_error;
		logic       auto_crc_error;
		logic       auto_timeout_error;
		logic       auto_not_issued;
	} auto_err_s;

	typedef struct packed {
		logic       tuned_clock_sel;
		logic       tuning_in_progress;
		logic [2:0] bus_speed_select;
		logic       speed_code_valid;
	} ctrl_s;

	function automatic logic [31:0] ctrl2_pack(input ctrl_s c, input auto_err_s a);
		logic [31:0] w;
		w = 32'h00000000;
		w[TUNED_BIT] = c.tuned_clock_sel;
		w[TUNE_START_BIT] = c.tuning_in_progress;
		w[SPEED_LSB +: 3] = c.bus_speed_select;
		w[7] = a.auto_stop_error;
		w[4:0] = {a.auto_index_error, a.auto_endbit_error, a.auto_crc_error,
			a.auto_timeout_error, a.auto_not_issued};
		return w;
	endfunction

endpackage

// file: rtl/sd_event_recorder.sv
`timescale 1ns/1ps
module sd_event_recorder
	import sd_irq_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        nrst_in,
	input  wire logic [31:0] event_in,
	input  wire logic [31:0] mask_in,
	input  wire logic [31:0] clear_in,
	output logic      [31:0] flags_out
);
	logic [31:0] flags_reg;
	logic [31:0] flags_next;
	logic [31:0] summary;

	// Set wins over a clear in the same cycle
	always_comb begin
		flags_next = (flags_reg & ~clear_in) | (event_in & mask_in & EVENT_BITS);
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			flags_reg <= RESET_VALUE;
		end else begin
			flags_reg <= flags_next;
		end
	end

	always_comb begin
		summary = flags_reg;
		summary[SUMMARY_BIT] = |(flags_reg & ERROR_BITS);
	end

	assign flags_out = summary;
endmodule

// file: rtl/sd_tune_ctrl.sv
`timescale 1ns/1ps
module sd_tune_ctrl (
	input  wire logic ref_clk_in,
	input  wire logic nrst_in,
	input  wire logic start_in,
	input  wire logic done_in,
	output logic      busy_out
);
	typedef enum logic [0:0] {
		TUNE_IDLE = 1'b0,
		TUNE_BUSY = 1'b1
	} tune_state_e;

	tune_state_e state_reg;
	tune_state_e state_next;

	always_comb begin
		case (state_reg)
			TUNE_IDLE: state_next = start_in ? TUNE_BUSY : TUNE_IDLE;
			TUNE_BUSY: state_next = done_in ? TUNE_IDLE : TUNE_BUSY;
			default:   state_next = TUNE_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			state_reg <= TUNE_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign busy_out = (state_reg == TUNE_BUSY);
endmodule

// file: rtl/sd_host_irq_gating.sv
// Functional notes
// - An event sets its flag only while its mask bit is one.
// - A flag raises the processor interrupt only while its enable bit is one.
// - Error events sit at bits 24 and 22 down to 16.
// - Boot done 14, boot ack 13, retune 12, card interrupt 8.
// - Read ready 5, write ready 4, block gap 2, data done 1, command done 0.
// - Enable register uses the same bit layout as the mask register.
// - Control bit 23 selects the tuned sampling clock.
// - Writing one to bit 22 starts tuning; reads one until tuning completes.
// - Bits 18:16 select bus speed mode; codes above four reserved.
// - Read-only bit 7 flags an error during automatic stop command.
// - Read-only bit 4 flags a wrong index in automatic command response.
// - Read-only bit 3 flags a bad end bit in automatic command response.
// - Read-only bit 2 flags a CRC failure in automatic command response.
// - Read-only bit 1 flags an automatic command response timeout.
// - Read-only bit 0 flags an automatic command never issued.
// - Summary error bit 15 reads one while any error flag is set, whatever its enable bit.
`timescale 1ns/1ps
module sd_host_irq_gating
	import sd_irq_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        nrst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic [31:0] event_in,
	input  wire logic [31:0] flag_clear_in,
	input  wire logic        auto_stop_error_in,
	input  wire logic        auto_index_error_in,
	input  wire logic        auto_endbit_error_in,
	input  wire logic        auto_crc_error_in,
	input  wire logic        auto_timeout_error_in,
	input  wire logic        auto_not_issued_in,
	input  wire logic        auto_err_clear_in,
	input  wire logic        tune_done_in,
	output logic             tune_start_out,
	output logic             tuned_clock_sel_out,
	output logic      [2:0]  bus_speed_select_out,
	output logic             speed_code_valid_out,
	output logic      [31:0] flags_out,
	output logic             cpu_irq_out,
	output logic             irq_out
);
	logic [31:0] event_flag_mask_reg;
	logic [31:0] event_irq_enable_reg;
	logic        tuned_reg;
	logic [2:0]  speed_reg;
	auto_err_s   auto_err_reg;
	auto_err_s   auto_err_set;
	logic [2:0]  istat_reg;
	logic [2:0]  istat_next;
	logic [2:0]  imask_reg;
	logic [2:0]  local_evt;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_q_reg;
	logic [31:0] flags;
	logic [31:0] wmask;
	logic        tune_busy;
	logic        tune_busy_d_reg;
	logic        tune_start;
	logic        cpu_irq_reg;
	logic        access;
	logic        wr;
	logic        rd;
	logic        mapped;
	ctrl_s       ctrl;

	assign access = psel_in & penable_in;
	assign wr     = access & pwrite_in;
	assign rd     = access & ~pwrite_in;
	assign mapped = (paddr_in == MASK_OFFSET) || (paddr_in == ENABLE_OFFSET) ||
		(paddr_in == CTRL2_OFFSET) || (paddr_in == FLAG_OFFSET) ||
		(paddr_in == ISTAT_OFFSET) || (paddr_in == IMASK_OFFSET);

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready_out  = 1'b1;
	assign pslverr_out = access & ~mapped;

	always_comb begin
		wmask = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
	end

	// Reserved bits are not stored, so they always read zero
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			event_flag_mask_reg <= RESET_VALUE;
		end else if (wr && paddr_in == MASK_OFFSET) begin
			event_flag_mask_reg <= ((event_flag_mask_reg & ~wmask) |
				(pwdata_in & wmask)) & EVENT_BITS;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			event_irq_enable_reg <= RESET_VALUE;
		end else if (wr && paddr_in == ENABLE_OFFSET) begin
			event_irq_enable_reg <= ((event_irq_enable_reg & ~wmask) |
				(pwdata_in & wmask)) & EVENT_BITS;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			tuned_reg <= 1'b0;
			speed_reg <= SPEED_SDR12;
		end else if (wr && paddr_in == CTRL2_OFFSET) begin
			if (pstrb_in[2]) begin
				tuned_reg <= pwdata_in[TUNED_BIT];
				speed_reg <= pwdata_in[SPEED_LSB +: 3];
			end
		end
	end

	// A one starts tuning; a zero is ignored since the bit tracks progress
	assign tune_start = wr && paddr_in == CTRL2_OFFSET && pstrb_in[2] &&
		pwdata_in[TUNE_START_BIT];

	sd_tune_ctrl u_tune (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.start_in   (tune_start),
		.done_in    (tune_done_in),
		.busy_out   (tune_busy)
	);

	always_comb begin
		auto_err_set.auto_stop_error    = auto_stop_error_in;
		auto_err_set.auto_index_error   = auto_index_error_in;
		auto_err_set.auto_endbit_error  = auto_endbit_error_in;
		auto_err_set.auto_crc_error     = auto_crc_error_in;
		auto_err_set.auto_timeout_error = auto_timeout_error_in;
		auto_err_set.auto_not_issued    = auto_not_issued_in;
	end

	// Engine clears the sticky bits at a new auto command; set wins
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			auto_err_reg <= '0;
		end else begin
			auto_err_reg <= (auto_err_clear_in ? '0 : auto_err_reg) | auto_err_set;
		end
	end

	sd_event_recorder u_rec (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.event_in   (event_in),
		.mask_in    (event_flag_mask_reg),
		.clear_in   (flag_clear_in),
		.flags_out  (flags)
	);

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			cpu_irq_reg <= 1'b0;
		end else begin
			cpu_irq_reg <= |(flags & event_irq_enable_reg & EVENT_BITS);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			tune_busy_d_reg <= 1'b0;
		end else begin
			tune_busy_d_reg <= tune_busy;
		end
	end

	// Local events: tuning done, any auto error, bad speed code
	always_comb begin
		local_evt[0] = tune_busy_d_reg & ~tune_busy;
		local_evt[1] = |auto_err_set;
		local_evt[2] = wr && paddr_in == CTRL2_OFFSET && pstrb_in[2] &&
			pwdata_in[SPEED_LSB +: 3] > SPEED_DDR50;
		istat_next = istat_reg;
		// Clear only what the read returned, so a setup-cycle event survives
		if (rd && paddr_in == ISTAT_OFFSET) begin
			istat_next = istat_reg & ~prdata_q_reg[2:0];
		end
		istat_next = istat_next | local_evt;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			istat_reg <= LOCAL_RESET;
		end else begin
			istat_reg <= istat_next;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			imask_reg <= LOCAL_RESET;
		end else if (wr && paddr_in == IMASK_OFFSET && pstrb_in[0]) begin
			imask_reg <= pwdata_in[2:0];
		end
	end

	always_comb begin
		ctrl.tuned_clock_sel    = tuned_reg;
		ctrl.tuning_in_progress = tune_busy;
		ctrl.bus_speed_select   = speed_reg;
		ctrl.speed_code_valid   = (speed_reg <= SPEED_DDR50);
	end

	always_comb begin
		case (paddr_in)
			MASK_OFFSET:   prdata_reg = event_flag_mask_reg;
			ENABLE_OFFSET: prdata_reg = event_irq_enable_reg;
			CTRL2_OFFSET:  prdata_reg = ctrl2_pack(ctrl, auto_err_reg);
			FLAG_OFFSET:   prdata_reg = flags;
			ISTAT_OFFSET:  prdata_reg = {29'h0, istat_reg};
			IMASK_OFFSET:  prdata_reg = {29'h0, imask_reg};
			default:       prdata_reg = 32'h00000000;
		endcase
	end

	// Read data captured at the setup edge, stable through the access
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			prdata_q_reg <= RESET_VALUE;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			prdata_q_reg <= prdata_reg;
		end
	end

	assign prdata_out           = prdata_q_reg;
	assign tune_start_out       = tune_start;
	assign tuned_clock_sel_out  = tuned_reg;
	assign bus_speed_select_out = speed_reg;
	assign speed_code_valid_out = ctrl.speed_code_valid;
	assign flags_out            = flags;
	assign cpu_irq_out          = cpu_irq_reg;
	assign irq_out              = |(istat_reg & imask_reg);
endmodule

// file: verif/irq_gating_props.sv
`timescale 1ns/1ps
module irq_gating_props
	import sd_irq_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        nrst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	input  wire logic [31:0] event_in,
	input  wire logic        tune_start_out,
	input  wire logic        tuned_clock_sel_out,
	input  wire logic [2:0]  bus_speed_select_out,
	input  wire logic        speed_code_valid_out,
	input  wire logic [31:0] flags_out,
	input  wire logic        cpu_irq_out
);
	localparam logic [31:0] SUM_MASK = 32'h00008000;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	sequence ctrl2_wr;
		psel_in && penable_in && pwrite_in && paddr_in == CTRL2_OFFSET && pstrb_in[2];
	endsequence
	flag_source_a: assert property ((flags_out & ~$past(flags_out | event_in | SUM_MASK)) == 32'h0)
		else $error("flag rose without event");
	irq_cause_a: assert property (cpu_irq_out |-> $past(flags_out & EVENT_BITS) != 32'h0)
		else $error("irq without flag");
	summary_a: assert property (flags_out[SUMMARY_BIT] == |(flags_out & ERROR_BITS))
		else $error("summary bit wrong");
	reserved_flags_a: assert property ((flags_out & ~(EVENT_BITS | SUM_MASK)) == 32'h0)
		else $error("reserved flag set");
	tune_pulse_a: assert property (ctrl2_wr ##0 pwdata_in[TUNE_START_BIT] |-> tune_start_out)
		else $error("tuning not started");
	tuned_write_a: assert property (ctrl2_wr |=> tuned_clock_sel_out == $past(pwdata_in[TUNED_BIT]))
		else $error("tuned select not written");
	speed_write_a: assert property (ctrl2_wr |=> bus_speed_select_out == $past(pwdata_in[18:16]))
		else $error("speed code not written");
	speed_valid_a: assert property (speed_code_valid_out == (bus_speed_select_out <= 3'h4))
		else $error("speed valid wrong");
endmodule
bind sd_host_irq_gating irq_gating_props props_u (.ref_clk_in, .nrst_in, .psel_in, .penable_in,
	.pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .event_in, .tune_start_out, .tuned_clock_sel_out,
	.bus_speed_select_out, .speed_code_valid_out, .flags_out, .cpu_irq_out);

// file: verif/cpu_irq_model.sv
`timescale 1ns/1ps
module cpu_irq_model (
	input  wire logic        ref_clk_in,
	input  wire logic        nrst_in,
	input  wire logic        irq_in,
	input  wire logic        svc_en_in,
	input  wire logic [3:0]  lat_in,
	input  wire logic [31:0] flags_in,
	output logic      [31:0] clear_out
);
	logic [3:0] wait_reg;
	// Level input: service repeats while the line stays high
	always_ff @(posedge ref_clk_in) begin
		clear_out <= 32'h0;
		if (!nrst_in || !svc_en_in || !irq_in) begin
			wait_reg <= 4'h0;
		end else if (wait_reg == lat_in) begin
			wait_reg <= 4'h0;
			clear_out <= flags_in;
		end else begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule

// file: verif/tb_sd_host_irq_gating.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module tb_sd_host_irq_gating
	import sd_irq_pkg::*;
;
	logic        ref_clk_in, nrst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
	logic        tune_done_in, auto_err_clear_in, tune_start_out, tuned_clock_sel_out, irq_out;
	logic        speed_code_valid_out, cpu_irq_out, svc_en, err_seen;
	logic [2:0]  bus_speed_select_out;
	logic [4:0]  ctl_seen;
	logic [3:0]  lat, pstrb_in;
	logic [5:0]  av;
	logic [7:0]  paddr_in;
	logic [31:0] pwdata_in, prdata_out, event_in, flag_clear_in, flags_out, seed, mask, en, acc, x;
	int          err_count, num_checks;
	sd_host_irq_gating dut_u (.ref_clk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
		.pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .event_in,
		.flag_clear_in, .auto_stop_error_in(av[5]), .auto_index_error_in(av[4]),
		.auto_endbit_error_in(av[3]), .auto_crc_error_in(av[2]), .auto_timeout_error_in(av[1]),
		.auto_not_issued_in(av[0]), .auto_err_clear_in, .tune_done_in, .tune_start_out,
		.tuned_clock_sel_out, .bus_speed_select_out, .speed_code_valid_out, .flags_out,
		.cpu_irq_out, .irq_out);
	cpu_irq_model cpu_u (.ref_clk_in, .nrst_in, .irq_in(cpu_irq_out), .svc_en_in(svc_en),
		.lat_in(lat), .flags_in(flags_out), .clear_out(flag_clear_in));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] exp_flags(input logic [31:0] f);
		return f | (32'(|(f & ERROR_BITS)) << SUMMARY_BIT);
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		// No fixed wait assumed; only the watchdog ends a stuck transfer
		do begin
			@(posedge ref_clk_in);
		end while (pready_out !== 1'b1);
		if (!w) `CHK("read", d, prdata_out)
		err_seen = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic pulse(input logic [31:0] e, input logic [5:0] a, input logic t, input logic c);
		@(posedge ref_clk_in);
		event_in <= e;
		av <= a;
		tune_done_in <= t;
		auto_err_clear_in <= c;
		@(posedge ref_clk_in);
		{event_in, av, tune_done_in, auto_err_clear_in} <= '0;
		acc = acc | (e & mask);
		@(negedge ref_clk_in);
	endtask
	task automatic drain();
		int n;
		n = 0;
		svc_en <= 1'b1;
		if ((acc & en) !== 32'h0) acc = 32'h0;
		while (flags_out !== exp_flags(acc) && n < 40) begin
			@(negedge ref_clk_in);
			n++;
		end
		`CHK("drain", exp_flags(acc), flags_out)
		// A late clear from the model must not hit the next event
		repeat (3) @(posedge ref_clk_in);
		svc_en <= 1'b0;
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		err_count++;
		test_done();
	end
	initial begin
		{nrst_in, psel_in, penable_in, pwrite_in, tune_done_in, auto_err_clear_in, svc_en} = '0;
		{paddr_in, pwdata_in, event_in, av, lat, acc, err_count, num_checks} = '0;
		seed = 32'h00000028;
		pstrb_in = 4'hF;
		repeat (6) @(posedge ref_clk_in);
		nrst_in <= 1'b1;
		apb(1'b0, MASK_OFFSET, RESET_VALUE);
		apb(1'b0, ENABLE_OFFSET, RESET_VALUE);
		apb(1'b0, CTRL2_OFFSET, RESET_VALUE);
		apb(1'b0, 8'h20, 32'h0);
		`CHK("slverr", 1'b1, err_seen)
		$display("test reset done");
		pstrb_in <= 4'h1;
		apb(1'b1, MASK_OFFSET, EVENT_BITS);
		pstrb_in <= 4'hF;
		apb(1'b0, MASK_OFFSET, EVENT_BITS & 32'h000000FF);
		$display("test strobe done");
		{mask, en} = {EVENT_BITS, EVENT_BITS};
		apb(1'b1, MASK_OFFSET, mask);
		apb(1'b1, ENABLE_OFFSET, en);
		apb(1'b0, ENABLE_OFFSET, en);
		for (int i = 0; i < 32; i++) begin
			if (EVENT_BITS[i]) begin
				x = rnd();
				lat <= x[3:0];
				pulse(32'h1 << i, 6'h00, 1'b0, 1'b0);
				`CHK("bit", exp_flags(acc), flags_out)
				@(negedge ref_clk_in);
				`CHK("cpu_irq", 1'b1, cpu_irq_out)
				drain();
			end
		end
		$display("test layout done");
		x = rnd();
		mask = x & EVENT_BITS;
		x = rnd();
		en = x & EVENT_BITS;
		apb(1'b1, MASK_OFFSET, mask);
		apb(1'b1, ENABLE_OFFSET, en);
		apb(1'b0, MASK_OFFSET, mask);
		for (int k = 0; k < 12; k++) begin
			x = (k == 0) ? ~mask : (k == 1) ? (mask & ~en) : rnd();
			pulse(x, 6'h00, 1'b0, 1'b0);
			`CHK("flags", exp_flags(acc), flags_out)
			@(negedge ref_clk_in);
			`CHK("cpu_irq", |(acc & en), cpu_irq_out)
		end
		drain();
		$display("test random done");
		for (int c = 0; c < 8; c++) begin
			x = {8'h00, c[0], 4'h0, c[2:0], 16'h0000};
			apb(1'b1, CTRL2_OFFSET, x);
			apb(1'b0, CTRL2_OFFSET, x);
			ctl_seen = {tuned_clock_sel_out, bus_speed_select_out, speed_code_valid_out};
			`CHK("ctl", {c[0], c[2:0], c[2:0] <= 3'h4}, ctl_seen)
		end
		apb(1'b0, ISTAT_OFFSET, 32'h00000004);
		apb(1'b1, IMASK_OFFSET, 32'h00000001);
		apb(1'b1, CTRL2_OFFSET, 32'h00C20000);
		apb(1'b0, CTRL2_OFFSET, 32'h00C20000);
		pulse(32'h0, 6'h00, 1'b1, 1'b0);
		@(negedge ref_clk_in);
		`CHK("irq", 1'b1, irq_out)
		apb(1'b0, CTRL2_OFFSET, 32'h00820000);
		apb(1'b0, ISTAT_OFFSET, 32'h00000001);
		@(negedge ref_clk_in);
		`CHK("irq", 1'b0, irq_out)
		for (int k = 0; k < 4; k++) begin
			x = (k == 0) ? 32'h3F : rnd();
			// Second pass sets and clears in one cycle: the set must win
			pulse(32'h0, x[5:0], 1'b0, k == 1);
			apb(1'b0, CTRL2_OFFSET, {24'h008200, x[5], 2'b00, x[4:0]});
			pulse(32'h0, 6'h00, 1'b0, 1'b1);
			apb(1'b0, CTRL2_OFFSET, 32'h00820000);
		end
		$display("test control done");
		nrst_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		nrst_in <= 1'b1;
		@(negedge ref_clk_in);
		`CHK("rst_flags", 32'h0, flags_out)
		apb(1'b0, MASK_OFFSET, RESET_VALUE);
		apb(1'b0, CTRL2_OFFSET, RESET_VALUE);
		`CHK("rst_irq", 1'b0, cpu_irq_out)
		$display("test midreset done");
		test_done();
	end
endmodule
